// file: common/cbs_pkg.sv
// ------------------------------------------------------------
// cbs_pkg
// ------------------------------------------------------------
// constants of the clock buffer smbus configuration bank
// assumes a single 250 mhz system clock
package cbs_pkg;

  // 7-bit smbus target address
  localparam logic [6:0] DEV_ADDR = 7'h6d;

  // byte indexes of the register bank
  localparam logic [7:0] OFS_OE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h01;
  localparam logic [7:0] OFS_EDGE = 8'h02;
  localparam logic [7:0] OFS_FREQ = 8'h03;
  localparam logic [7:0] OFS_RSVD = 8'h04;
  localparam logic [7:0] OFS_REVID = 8'h05;
  localparam logic [7:0] OFS_PARTID = 8'h06;
  localparam logic [7:0] OFS_LEN = 8'h07;
  localparam logic [7:0] NUM_BYTES = 8'h08;

  // field positions
  localparam int OE1_BIT = 5;
  localparam int OE0_BIT = 3;
  localparam int LAT_HI_BIT = 7;
  localparam int LAT_LO_BIT = 6;
  localparam int SOFT_SEL_BIT = 5;
  localparam int SOFT_HI_BIT = 4;
  localparam int SOFT_LO_BIT = 3;
  localparam int AMP_HI_BIT = 1;
  localparam int AMP_LO_BIT = 0;
  localparam int EDGE1_BIT = 5;
  localparam int EDGE0_BIT = 3;
  localparam int FSEL_EN_BIT = 5;
  localparam int FSEL_HI_BIT = 4;
  localparam int FSEL_LO_BIT = 3;
  localparam int EDGE_FB_BIT = 0;
  localparam int LEN_W = 5;

  // reset values and writable masks
  localparam logic [7:0] RST_OE = 8'hff;
  localparam logic [7:0] RST_MODE = 8'h06;
  localparam logic [7:0] RST_EDGE = 8'hff;
  localparam logic [7:0] RST_FREQ = 8'h07;
  localparam logic [7:0] RST_RSVD = 8'hff;
  localparam logic [7:0] RST_LEN = 8'h08;
  localparam logic [7:0] MASK_OE = 8'h28;
  localparam logic [7:0] MASK_MODE = 8'h3b;
  localparam logic [7:0] MASK_EDGE = 8'h28;
  localparam logic [7:0] MASK_FREQ = 8'h39;
  localparam logic [7:0] MASK_LEN = 8'h1f;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // identity codes, values arbitrary
  localparam logic [3:0] REV_CODE = 4'h5;
  localparam logic [3:0] MAKER_CODE = 4'ha;
  localparam logic [1:0] FAMILY_CODE = 2'h1;
  localparam logic [5:0] PART_CODE = 6'h2a;

  // pin synchroniser
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h0f;
  // clocks after reset release before the synchronised straps are valid
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // byte roles in a transfer
  localparam logic [1:0] ROLE_ADDR = 2'h0;
  localparam logic [1:0] ROLE_CMD = 2'h1;
  localparam logic [1:0] ROLE_CNT = 2'h2;
  localparam logic [1:0] ROLE_DATA = 2'h3;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX = 5'b00010,
    ST_ACK = 5'b00100,
    ST_TX = 5'b01000,
    ST_HACK = 5'b10000
  } cbs_state_e;

  // reset value of each byte
  function automatic logic [7:0] cbs_rst_val(input logic [7:0] idx);
    unique case (idx)
      OFS_OE: cbs_rst_val = RST_OE;
      OFS_MODE: cbs_rst_val = RST_MODE;
      OFS_EDGE: cbs_rst_val = RST_EDGE;
      OFS_FREQ: cbs_rst_val = RST_FREQ;
      OFS_RSVD: cbs_rst_val = RST_RSVD;
      OFS_REVID: cbs_rst_val = {REV_CODE, MAKER_CODE};
      OFS_PARTID: cbs_rst_val = {FAMILY_CODE, PART_CODE};
      OFS_LEN: cbs_rst_val = RST_LEN;
      default: cbs_rst_val = UNMAPPED_READ;
    endcase
  endfunction

  // bits of each byte that the host may change
  function automatic logic [7:0] cbs_wmask(input logic [7:0] idx);
    unique case (idx)
      OFS_OE: cbs_wmask = MASK_OE;
      OFS_MODE: cbs_wmask = MASK_MODE;
      OFS_EDGE: cbs_wmask = MASK_EDGE;
      OFS_FREQ: cbs_wmask = MASK_FREQ;
      OFS_LEN: cbs_wmask = MASK_LEN;
      default: cbs_wmask = 8'h00;
    endcase
  endfunction

endpackage

// file: core/cbs_regs.sv
// ------------------------------------------------------------
// cbs_regs
// ------------------------------------------------------------
// the eight configuration bytes, strap latch and read mux
// assumes synchronised mode straps and one write per cycle
`timescale 1ns/100ps
module cbs_regs (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [1:0] strap_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o,
  output logic [7:0] oe_byte_o,
  output logic [7:0] mode_byte_o,
  output logic [7:0] edge_byte_o,
  output logic [7:0] freq_byte_o,
  output logic [cbs_pkg::LEN_W-1:0] len_o
);
  import cbs_pkg::*;

  logic [7:0] store_q [8];
  logic [1:0] strap_q;
  logic strap_done_q;
  logic [1:0] strap_wait_q;
  logic [7:0] view [8];

  // one byte per index, reserved bits keep their defaults
  for (genvar i = 0; i < 8; i++) begin : g_byte
    localparam logic [7:0] IDX = 8'(i);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        store_q[i] <= cbs_rst_val(IDX);
      end else if (we_i && waddr_i == IDX) begin
        store_q[i] <= (store_q[i] & ~cbs_wmask(IDX)) |
                      (wdata_i & cbs_wmask(IDX));
      end
    end
    assign view[i] = (IDX == OFS_MODE) ?
      {strap_q, store_q[i][5:0]} : store_q[i];
  end

  // mode straps caught once the synchroniser shows the real pins,
  // earlier edges would only see its reset value
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_q <= 2'h0;
      strap_done_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else if (strap_wait_q != STRAP_WAIT) begin
      strap_wait_q <= strap_wait_q + 2'h1;
    end else if (!strap_done_q) begin
      strap_q <= strap_i;
      strap_done_q <= 1'b1;
    end
  end

  // read mux, out of range reads give a fixed value
  assign rdata_o = (raddr_i < NUM_BYTES) ? view[raddr_i[2:0]] :
                   UNMAPPED_READ;
  assign oe_byte_o = store_q[0];
  assign mode_byte_o = view[1];
  assign edge_byte_o = store_q[2];
  assign freq_byte_o = store_q[3];
  assign len_o = store_q[7][LEN_W-1:0];

  chk_rsvd_ones: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (raddr_i == OFS_RSVD) |-> (rdata_o == RST_RSVD))
    else $error("reserved byte did not read all ones");

  chk_rsvd_kept: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (we_i && waddr_i == OFS_OE) |=>
    ((store_q[0] & ~MASK_OE) == (RST_OE & ~MASK_OE)))
    else $error("reserved bits of byte zero changed");

endmodule

// file: core/cbs_smbus_bank.sv
// ------------------------------------------------------------
// cbs_smbus_bank
// ------------------------------------------------------------
// smbus target with block read and write into the config bank
// assumes scl and sda pins sampled by the 250 mhz clock
//
// Contract
// - output forced low/low while its enable bit is zero
// - latched mode straps read back in mode byte bits 7:6
// - select bit picks strap mode or soft mode, resets to 0
// - soft mode bits stored, reset 0, used only when selected
// - two bit amplitude field, 0.6 to 0.9 v, resets to 10
// - per-output edge rate bits 5 and 3, 1 fast, reset 1
// - soft frequency enable bit, resets to 0
// - frequency choice bits act only while enable is 1
// - bit 0 of frequency byte is feedback edge rate, reset 1
// - byte four is reserved and reads all ones
// - byte five holds revision code and maker code
// - byte six holds family type and part code
// - five bit read length in byte seven, default 8
// - answers target address 1101101, eighth bit is direction
// - block write: address, index, count, data, each acked
// - block read: count then data, host nacks and stops
// - per-output enable bits 5 and 3 of byte zero, reset 1
`timescale 1ns/100ps
module cbs_smbus_bank (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic oe0_n_i,
  input wire logic oe1_n_i,
  input wire logic [1:0] mode_pin_i,
  output logic out0_run_o,
  output logic out1_run_o,
  output logic [1:0] loop_mode_o,
  output logic [1:0] amplitude_o,
  output logic edge_rate_out0_o,
  output logic edge_rate_out1_o,
  output logic edge_rate_feedback_o,
  output logic freq_soft_en_o,
  output logic [1:0] freq_choice_o
);
  import cbs_pkg::*;

  // ----------------------------------------------------------
  // pin synchronisers and bus edges
  // ----------------------------------------------------------

  logic [SYNC_W-1:0] pins_s;
  logic [1:0] strap_s;
  logic scl_s, sda_s, oe0_n_s, oe1_n_s;
  logic scl_p_q, sda_p_q, scl_rise, scl_fall, bus_start, bus_stop;

  cbs_sync #(
    .W(SYNC_W),
    .RST(SYNC_RST)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i({mode_pin_i, oe1_n_i, oe0_n_i, sda_i, scl_i}),
    .sync_o(pins_s)
  );

  // split the synchronised bundle
  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign oe0_n_s = pins_s[2];
  assign oe1_n_s = pins_s[3];
  assign strap_s = pins_s[5:4];

  // previous bus levels for edge detection
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // start and stop are sda edges while scl stays high
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ----------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------

  cbs_state_e state_q, state_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d;
  logic [1:0] role_q, role_d;
  logic [7:0] idx_q, idx_d, wleft_q, wleft_d;
  logic rd_q, rd_d, ack_q, ack_d, ackph_q, ackph_d, oe_d, reg_we;
  logic [7:0] rx_byte, len_byte, rdata;
  logic [7:0] oe_byte, mode_byte, edge_byte, freq_byte;
  logic [LEN_W-1:0] len;
  logic byte_done, addr_hit;

  // byte assembly and address decode
  assign rx_byte = {rx_q[6:0], sda_s};
  assign byte_done = scl_rise && (bit_q == LAST_BIT);
  assign addr_hit = (rx_byte[7:1] == DEV_ADDR);
  assign len_byte = {{(8 - LEN_W){1'b0}}, len};

  // next state of the byte engine
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    rx_d = rx_q;
    tx_d = tx_q;
    role_d = role_q;
    idx_d = idx_q;
    wleft_d = wleft_q;
    rd_d = rd_q;
    ack_d = ack_q;
    ackph_d = ackph_q;
    oe_d = sda_oe_o;
    reg_we = 1'b0;
    if (bus_start) begin
      state_d = ST_RX;
      bit_d = 3'h0;
      role_d = ROLE_ADDR;
      ackph_d = 1'b0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      ackph_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: oe_d = 1'b0;
        ST_RX: begin
          if (scl_rise) begin
            rx_d = rx_byte;
            bit_d = bit_q + 3'h1;
          end
          if (byte_done) begin
            state_d = ST_ACK;
            ack_d = 1'b1;
            unique case (role_q)
              ROLE_ADDR: begin
                ack_d = addr_hit;
                rd_d = rx_byte[0];
                role_d = ROLE_CMD;
              end
              ROLE_CMD: begin
                idx_d = rx_byte;
                role_d = ROLE_CNT;
              end
              ROLE_CNT: begin
                wleft_d = rx_byte;
                role_d = ROLE_DATA;
              end
              ROLE_DATA: begin
                if (wleft_q != 8'h00) begin
                  reg_we = 1'b1;
                  idx_d = idx_q + 8'h01;
                  wleft_d = wleft_q - 8'h01;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall && !ackph_q) begin
            // pull sda low for the acknowledge clock
            oe_d = ack_q;
            ackph_d = ack_q;
            if (!ack_q) state_d = ST_IDLE;
          end else if (scl_fall) begin
            ackph_d = 1'b0;
            bit_d = 3'h0;
            if (rd_q) begin
              // read: count byte goes out first
              state_d = ST_TX;
              oe_d = ~len_byte[7];
              tx_d = {len_byte[6:0], 1'b0};
            end else begin
              state_d = ST_RX;
              oe_d = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_d = bit_q + 3'h1;
            if (bit_q == LAST_BIT) state_d = ST_HACK;
          end else if (scl_fall) begin
            oe_d = ~tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
          end
        end
        ST_HACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
          end else if (scl_rise) begin
            bit_d = 3'h0;
            if (!sda_s) begin
              state_d = ST_TX;
              tx_d = rdata;
              idx_d = idx_q + 8'h01;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      bit_q <= 3'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      role_q <= ROLE_ADDR;
      idx_q <= 8'h00;
      wleft_q <= 8'h00;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      ackph_q <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      role_q <= role_d;
      idx_q <= idx_d;
      wleft_q <= wleft_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      ackph_q <= ackph_d;
      sda_oe_o <= oe_d;
      sda_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // register bank
  // ----------------------------------------------------------

  cbs_regs u_regs (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .strap_i(strap_s),
    .we_i(reg_we),
    .waddr_i(idx_q),
    .wdata_i(rx_byte),
    .raddr_i(idx_q),
    .rdata_o(rdata),
    .oe_byte_o(oe_byte),
    .mode_byte_o(mode_byte),
    .edge_byte_o(edge_byte),
    .freq_byte_o(freq_byte),
    .len_o(len)
  );

  // ----------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------

  logic run0, run1;
  logic [1:0] mode_eff, freq_eff;

  // register enable low overrides the pin enable
  assign run0 = oe_byte[OE0_BIT] & ~oe0_n_s;
  assign run1 = oe_byte[OE1_BIT] & ~oe1_n_s;
  assign mode_eff = mode_byte[SOFT_SEL_BIT] ?
    {mode_byte[SOFT_HI_BIT], mode_byte[SOFT_LO_BIT]} :
    {mode_byte[LAT_HI_BIT], mode_byte[LAT_LO_BIT]};
  assign freq_eff = freq_byte[FSEL_EN_BIT] ?
    {freq_byte[FSEL_HI_BIT], freq_byte[FSEL_LO_BIT]} :
    2'h0;

  // every control output is a flip-flop
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out0_run_o <= 1'b0;
      out1_run_o <= 1'b0;
      loop_mode_o <= 2'h0;
      amplitude_o <= RST_MODE[1:0];
      edge_rate_out0_o <= 1'b1;
      edge_rate_out1_o <= 1'b1;
      edge_rate_feedback_o <= 1'b1;
      freq_soft_en_o <= 1'b0;
      freq_choice_o <= 2'h0;
    end else begin
      out0_run_o <= run0;
      out1_run_o <= run1;
      loop_mode_o <= mode_eff;
      amplitude_o <= mode_byte[AMP_HI_BIT:AMP_LO_BIT];
      edge_rate_out0_o <= edge_byte[EDGE0_BIT];
      edge_rate_out1_o <= edge_byte[EDGE1_BIT];
      edge_rate_feedback_o <= freq_byte[EDGE_FB_BIT];
      freq_soft_en_o <= freq_byte[FSEL_EN_BIT];
      freq_choice_o <= freq_eff;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------

  sequence s_read_ack_end;
    state_q == ST_ACK && ackph_q && scl_fall && rd_q &&
    !bus_start && !bus_stop;
  endsequence
  // falling scl that opens the host acknowledge bit
  sequence s_hack_fall;
    state_q == ST_HACK && scl_fall &&
    !bus_start && !bus_stop;
  endsequence
  chk_oe_forced_low: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!oe_byte[OE0_BIT] || oe0_n_s) |=> !out0_run_o)
    else $error("output 0 ran with enable low");
  chk_mode_source: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !mode_byte[SOFT_SEL_BIT] |=>
    loop_mode_o == $past(mode_byte[7:6]))
    else $error("strap mode not used while soft select is 0");
  chk_freq_gated: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !freq_byte[FSEL_EN_BIT] |=> freq_choice_o == 2'h0)
    else $error("frequency choice leaked while disabled");
  chk_addr_decode: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (state_q == ST_RX && role_q == ROLE_ADDR && byte_done &&
     !bus_start && !bus_stop) |=>
    (ack_q == (rx_q[7:1] == DEV_ADDR)) && state_q == ST_ACK)
    else $error("address acknowledge decision wrong");
  chk_write_bounded: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    reg_we |-> (wleft_q != 8'h00 && role_q == ROLE_DATA && !rd_q))
    else $error("register written outside the byte count");
  chk_count_first: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_read_ack_end |=> state_q == ST_TX &&
    tx_q == {len_byte[6:0], 1'b0} && sda_oe_o)
    else $error("read did not start with the count byte");
  chk_host_ack_release: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_hack_fall |=> !sda_oe_o && state_q == ST_HACK)
    else $error("sda not released for host acknowledge");
  chk_idle_quiet: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $past(bus_stop) |-> !sda_oe_o && state_q == ST_IDLE)
    else $error("sda still driven after stop");
  chk_len_reset: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> len == RST_LEN[LEN_W-1:0])
    else $error("read length not 8 after reset");

endmodule

// file: core/cbs_sync.sv
// ------------------------------------------------------------
// cbs_sync
// ------------------------------------------------------------
// two flip-flop synchroniser for a bundle of pins
// assumes each bit is an independent level
`timescale 1ns/100ps
module cbs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST;
      sync_o <= RST;
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end

endmodule

// file: tb/cbs_host.sv
// ----------------------------------------
// cbs_host: smbus host model for block transfers
// ----------------------------------------
// assumes the bench resolves open-drain sda with a pull-up
`timescale 1ns/100ps
module cbs_host
  import cbs_pkg::*;
(
  input wire logic clock_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // bus idles released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // phases of 4 or 8 clocks keep the device's sampling clean
  task automatic hw(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  // start or repeated start, clock left low
  task automatic start();
    sda_pull_o = 1'b0;
    hw(8);
    scl_o = 1'b1;
    hw(8);
    sda_pull_o = 1'b1;
    hw(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    hw(4);
    sda_pull_o = 1'b1;
    hw(8);
    scl_o = 1'b1;
    hw(8);
    sda_pull_o = 1'b0;
    hw(8);
  endtask
  // data changes only while scl is low
  task automatic bit1(input logic b, output logic r);
    hw(4);
    sda_pull_o = ~b;
    hw(4);
    scl_o = 1'b1;
    hw(4);
    r = sda_i;
    hw(4);
    scl_o = 1'b0;
  endtask
  // byte out msb first, ack returned
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(d[i], r);
    bit1(1'b1, r);
    ack = ~r;
  endtask
  // byte in, then host ack or nack
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
    bit1(~ack, r);
  endtask
  // block write: address, index, count, data, stop
  task automatic wr(input logic [6:0] a, input logic [7:0] idx,
                    input logic [7:0] d[$], output logic ok);
    logic k;
    start();
    put({a, 1'b0}, ok);
    if (ok) begin
      put(idx, k);
      ok &= k;
      put(8'(d.size()), k);
      ok &= k;
      foreach (d[i]) begin
        put(d[i], k);
        ok &= k;
      end
    end
    stop();
  endtask
  // block read: index, repeated start, count, data, nack, stop
  task automatic rd(input logic [7:0] idx, input int n,
                    output logic [7:0] cnt, output logic [7:0] d[$]);
    logic k;
    logic [7:0] b;
    d = {};
    start();
    put({DEV_ADDR, 1'b0}, k);
    put(idx, k);
    start();
    put({DEV_ADDR, 1'b1}, k);
    get(1'b1, cnt);
    for (int i = 0; i < n; i++) begin
      get(i < n - 1, b);
      d.push_back(b);
    end
    stop();
  endtask
endmodule

// file: tb/cbs_smbus_bank_tb.sv
// ----------------------------------------
// cbs_smbus_bank_tb: random block writes with read-back
// ----------------------------------------
// assumes the host model above on the smbus pins
`timescale 1ns/100ps
module cbs_smbus_bank_tb;
  import cbs_pkg::*;
  logic clock_i, rst_n_i, oe0_n_i, oe1_n_i, scl, pull, sda_o, sda_oe_o;
  logic out0_run_o, out1_run_o, e0, e1, efb, fen, ok;
  logic [1:0] mode_pin_i, loop_mode_o, amplitude_o, freq_choice_o;
  logic [7:0] cnt;
  logic [7:0] m [8];
  logic [7:0] q [$];
  int error_cnt, n_tests;
  // open-drain line with pull-up
  wire logic sda = ~(pull | (sda_oe_o & ~sda_o));
  cbs_smbus_bank dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .oe0_n_i(oe0_n_i),
    .oe1_n_i(oe1_n_i), .mode_pin_i(mode_pin_i), .out0_run_o(out0_run_o),
    .out1_run_o(out1_run_o), .loop_mode_o(loop_mode_o),
    .amplitude_o(amplitude_o), .edge_rate_out0_o(e0),
    .edge_rate_out1_o(e1), .edge_rate_feedback_o(efb),
    .freq_soft_en_o(fen), .freq_choice_o(freq_choice_o));
  cbs_host host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl),
    .sda_pull_o(pull));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [7:0] rst_of(input int i);
    case (i)
      1: return {mode_pin_i, 6'h06};
      3: return 8'h07;
      5: return {REV_CODE, MAKER_CODE};
      6: return {FAMILY_CODE, PART_CODE};
      7: return 8'h08;
      default: return 8'hff;
    endcase
  endfunction
  function automatic logic [7:0] wmask(input int i);
    case (i)
      0, 2: return 8'h28;
      1: return 8'h3b;
      3: return 8'h39;
      7: return 8'h1f;
      default: return 8'h00;
    endcase
  endfunction
  task automatic do_reset();
    rst_n_i = 1'b0;
    mode_pin_i = 2'($urandom);
    repeat (3) @(negedge clock_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clock_i);
    for (int i = 0; i < 8; i++) m[i] = rst_of(i);
  endtask
  // control outputs against the model bytes and pins
  task automatic outs();
    chk(8'(out0_run_o), 8'(m[0][3] & ~oe0_n_i));
    chk(8'(out1_run_o), 8'(m[0][5] & ~oe1_n_i));
    chk(8'(loop_mode_o), 8'(m[1][5] ? m[1][4:3] : m[1][7:6]));
    chk(8'(amplitude_o), 8'(m[1][1:0]));
    chk({6'h0, e1, e0}, {6'h0, m[2][5], m[2][3]});
    chk(8'(fen), 8'(m[3][5]));
    chk(8'(freq_choice_o), 8'(m[3][5] ? m[3][4:3] : 2'b00));
    chk(8'(efb), 8'(m[3][0]));
  endtask
  // read all bytes plus one unmapped index
  task automatic readall();
    host.rd(8'h00, 9, cnt, q);
    chk(cnt, {3'h0, m[7][4:0]});
    for (int i = 0; i < 8; i++) begin
      chk(q[i], m[i]);
    end
    chk(q[8], 8'h00);
  endtask
  initial begin
    error_cnt = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    {oe1_n_i, oe0_n_i, mode_pin_i} = 4'h0;
    void'($urandom(65705));
    // reset twice to latch two strap values
    repeat (2) begin
      do_reset();
      outs();
      readall();
    end
    // random full-bank writes, select and enable bits alternate
    for (int k = 0; k < 4; k++) begin
      q = {};
      for (int i = 0; i < 8; i++) q.push_back(8'($urandom));
      q[1][5] = k[0];
      q[3][5] = k[0];
      host.wr(DEV_ADDR, 8'h00, q, ok);
      chk(8'(ok), 8'h01);
      for (int i = 0; i < 8; i++) begin
        m[i] = (m[i] & ~wmask(i)) | (q[i] & wmask(i));
      end
      {oe1_n_i, oe0_n_i} = 2'($urandom);
      repeat (4) @(negedge clock_i);
      outs();
      readall();
    end
    // wrong address, read-only bytes, unmapped index, zero length
    q = {8'h00, 8'h00, 8'h00, 8'h00};
    host.wr(7'h6c, 8'h04, q, ok);
    chk(8'(ok), 8'h00);
    host.wr(DEV_ADDR, 8'h08, q, ok);
    chk(8'(ok), 8'h01);
    host.wr(DEV_ADDR, 8'h04, q, ok);
    chk(8'(ok), 8'h01);
    m[7] = m[7] & 8'he0;
    readall();
    summarize();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clock_i);
    error_cnt++;
    summarize();
  end
endmodule
